// [core/csrb_defines.vh]
`ifndef CSRB_DEFINES_VH
`define CSRB_DEFINES_VH
// Functional notes
// - Four groups, each decoded by its owner
// - PHY registers reached only through MAC relay
// - Third base: low half little, high big
// - Read-only returns value, ignores writes
// - Write-only accepts writes, reads unspecified
// - Writing one clears, zero leaves bit
// - Read returns value then clears; writes ignored
// - Latch low holds until read, then follows cause
// - Latch high holds until read, then follows cause
// - Self-clearing bit returns zero after action
// - Reset-immune bits keep state on soft reset
// - Read/write bit stores and returns value
// - Soft reset restores non-immune control bits

// Bit attribute codes
`define CSRB_ATTR_RW 3'h0
`define CSRB_ATTR_RO 3'h1
`define CSRB_ATTR_WO 3'h2
`define CSRB_ATTR_W1C 3'h3
`define CSRB_ATTR_RDCLR 3'h4
`define CSRB_ATTR_LATLO 3'h5
`define CSRB_ATTR_LATHI 3'h6
`define CSRB_ATTR_SELFCLR 3'h7

// Window layout
`define CSRB_AW 10
`define CSRB_HALF_BIT 9
`define CSRB_DMA_LAST 9'h0bc
`define CSRB_SYS_LAST 9'h0fc

// Block-owned register offsets
`define CSRB_OFF_CTRL 9'h0e4
`define CSRB_OFF_STS 9'h0e8
`define CSRB_OFF_CMD 9'h0ec
`define CSRB_OFF_PHY_CMD 9'h1a4
`define CSRB_OFF_PHY_DATA 9'h1a8

// Field positions
`define CSRB_CTRL_ACT_BIT 16
`define CSRB_PCMD_WR_BIT 5
`define CSRB_PCMD_BUSY_BIT 31
`define CSRB_PHY_REG_CTRL 5'h00
`define CSRB_PHY_REG_STS 5'h01

// Reset values
`define CSRB_ZERO32 32'h0000_0000
`endif

// [core/csrb_bit_cell.v]
`timescale 1ns/1ns
`default_nettype none
`include "csrb_defines.vh"
module csrb_bit_cell #(
	parameter [2:0] ATTR = `CSRB_ATTR_RW,
	parameter [0:0] DEF = 1'b0,
	parameter [0:0] IMMUNE = 1'b0
) (
	// Clock and resets
	input wire clock_i,
	input wire rst_n_i,
	input wire soft_rst_i,
	// Access strobes
	input wire wr_i,
	input wire wbit_i,
	input wire rd_i,
	// Hardware side: event, cause, live value or action done
	input wire hw_i,
	// Value and read value
	output wire q_o,
	output wire rbit_o
);
	reg q;
	reg hw_d;
	wire rise;
	wire srst;
	assign rise = hw_i & ~hw_d;
	assign srst = soft_rst_i & ~IMMUNE;
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			q <= DEF;
			hw_d <= 1'b0;
		end else begin
			hw_d <= hw_i;
			if (srst && (ATTR != `CSRB_ATTR_RO)) begin
				q <= DEF;
			end else begin
				case (ATTR)
					`CSRB_ATTR_RW, `CSRB_ATTR_WO: begin
						if (wr_i) begin
							q <= wbit_i;
						end
					end
					`CSRB_ATTR_W1C: begin
						if (hw_i) begin
							q <= 1'b1;
						end else if (wr_i && wbit_i) begin
							q <= 1'b0;
						end
					end
					`CSRB_ATTR_RDCLR: begin
						if (hw_i) begin
							q <= 1'b1;
						end else if (rd_i) begin
							q <= 1'b0;
						end
					end
					`CSRB_ATTR_LATLO, `CSRB_ATTR_LATHI: begin
						if (rise) begin
							q <= 1'b1;
						end else if (rd_i) begin
							q <= 1'b0;
						end
					end
					`CSRB_ATTR_SELFCLR: begin
						if (wr_i && wbit_i) begin
							q <= 1'b1;
						end else if (hw_i) begin
							q <= 1'b0;
						end
					end
					default: begin
						q <= q;
					end
				endcase
			end
		end
	end
	assign q_o = (ATTR == `CSRB_ATTR_RO) ? hw_i :
		(ATTR == `CSRB_ATTR_LATLO) ? ~(q | hw_i) :
		(ATTR == `CSRB_ATTR_LATHI) ? (q | hw_i) : q;
	assign rbit_o = (ATTR == `CSRB_ATTR_WO) ? 1'b0 : q_o;
endmodule // csrb_bit_cell
`default_nettype wire

// [core/csrb_grp_decode.v]
`timescale 1ns/1ns
`default_nettype none
`include "csrb_defines.vh"
module csrb_grp_decode (
	// Access
	input wire [`CSRB_AW-1:0] addr_i,
	input wire cfg_i,
	// Window setup
	input wire third_bar_i,
	input wire big_endian_i,
	// Group selects
	output reg sys_o,
	output reg dma_o,
	output reg mac_o,
	output reg cfg_o,
	output wire [`CSRB_AW-2:0] off_o,
	output wire swap_o
);
	wire half_ok;
	assign off_o = addr_i[`CSRB_AW-2:0];
	assign half_ok = ~third_bar_i | (addr_i[`CSRB_HALF_BIT] == big_endian_i);
	assign swap_o = third_bar_i & big_endian_i;
	always @* begin
		sys_o = 1'b0;
		dma_o = 1'b0;
		mac_o = 1'b0;
		cfg_o = 1'b0;
		if (cfg_i) begin
			cfg_o = 1'b1;
		end else if (!half_ok) begin
			cfg_o = 1'b0;
		end else if (off_o <= `CSRB_DMA_LAST) begin
			dma_o = 1'b1;
		end else if (off_o <= `CSRB_SYS_LAST) begin
			sys_o = 1'b1;
		end else begin
			mac_o = 1'b1;
		end
	end
endmodule // csrb_grp_decode
`default_nettype wire

// [core/csrb_csr_space.v]
`timescale 1ns/1ns
`default_nettype none
`include "csrb_defines.vh"
module csrb_csr_space #(
	parameter CW = 8,
	parameter EW = 8,
	parameter PW = 4,
	parameter PDW = 16
) (
	// Clock and resets
	input wire clock_i,
	input wire rst_n_i,
	input wire soft_rst_i,
	// Host access
	input wire acc_valid_i,
	input wire acc_write_i,
	input wire acc_cfg_i,
	input wire [`CSRB_AW-1:0] acc_addr_i,
	input wire [31:0] acc_wdata_i,
	input wire acc_commit_i,
	input wire acc_abort_i,
	output wire acc_ready_o,
	output wire acc_rvalid_o,
	output reg [31:0] acc_rdata_o,
	// Window setup
	input wire third_bar_i,
	input wire big_endian_i,
	// Group selects toward owning units
	output wire grp_sys_o,
	output wire grp_dma_o,
	output wire grp_mac_o,
	output wire grp_cfg_o,
	output wire [`CSRB_AW-2:0] grp_off_o,
	// Device side of the block-owned registers
	output wire [2*CW-1:0] ctrl_o,
	output wire action_o,
	output wire [CW-1:0] cmd_o,
	output reg cmd_stb_o,
	input wire [EW-1:0] evt_w1c_i,
	input wire [EW-1:0] evt_rc_i,
	input wire [EW-1:0] live_i,
	// PHY side
	input wire [PW-1:0] phy_ll_cause_i,
	input wire [PW-1:0] phy_lh_cause_i,
	output wire [PDW-1:0] phy_ctrl_o
);
	wire sys_sel;
	wire mac_sel;
	wire [`CSRB_AW-2:0] off;
	wire swap;
	wire take;
	wire [31:0] wd;
	reg pend;
	reg [`CSRB_AW-2:0] pend_off;
	reg pend_sys;
	reg pend_mac;
	reg phy_done;
	reg [31:0] rmux;
	wire rd_commit;
	wire wr_ctrl;
	wire wr_sts;
	wire wr_cmd;
	wire wr_pcmd;
	wire wr_pdata;
	wire rd_sts;
	wire [2*CW:0] ctrl_rb;
	wire [3*EW-1:0] sts_rb;
	wire [CW-1:0] cmd_rb;
	wire [`CSRB_PCMD_WR_BIT:0] pcmd_q;
	wire busy;
	wire [PDW-1:0] pdata_q;
	wire [2*PW-1:0] psts_q;
	wire relay_go;
	wire relay_wr;
	wire relay_rd;
	wire [4:0] relay_addr;
	wire phy_ctrl_wr;
	wire phy_sts_rd;
	wire pdata_load;
	reg [PDW-1:0] phy_rval;

	csrb_grp_decode u_dec (
		.addr_i(acc_addr_i),
		.cfg_i(acc_cfg_i),
		.third_bar_i(third_bar_i),
		.big_endian_i(big_endian_i),
		.sys_o(sys_sel),
		.dma_o(grp_dma_o),
		.mac_o(mac_sel),
		.cfg_o(grp_cfg_o),
		.off_o(off),
		.swap_o(swap)
	);
	assign grp_sys_o = sys_sel;
	assign grp_mac_o = mac_sel;
	assign grp_off_o = off;

	// Host handshake: one outstanding read, side effects on commit
	assign acc_ready_o = ~pend;
	assign acc_rvalid_o = pend;
	assign take = acc_valid_i & acc_ready_o;
	assign rd_commit = pend & acc_commit_i & ~acc_abort_i;
	assign wd = swap ? {acc_wdata_i[7:0], acc_wdata_i[15:8], acc_wdata_i[23:16], acc_wdata_i[31:24]}
		: acc_wdata_i;

	// Write strobes, only at block-owned offsets
	assign wr_ctrl = take & acc_write_i & sys_sel & (off == `CSRB_OFF_CTRL);
	assign wr_sts = take & acc_write_i & sys_sel & (off == `CSRB_OFF_STS);
	assign wr_cmd = take & acc_write_i & sys_sel & (off == `CSRB_OFF_CMD);
	assign wr_pcmd = take & acc_write_i & mac_sel & (off == `CSRB_OFF_PHY_CMD) & ~busy;
	assign wr_pdata = take & acc_write_i & mac_sel & (off == `CSRB_OFF_PHY_DATA) & ~busy;
	assign rd_sts = rd_commit & pend_sys & (pend_off == `CSRB_OFF_STS);

	// Control: plain bits, reset-immune bits, one self-clearing action bit
	genvar i;
	generate
		for (i = 0; i < 2*CW; i = i + 1) begin : g_ctrl
			csrb_bit_cell #(
				.ATTR(`CSRB_ATTR_RW),
				.DEF(1'b0),
				.IMMUNE(i >= CW)
			) u_cell (
				.clock_i(clock_i),
				.rst_n_i(rst_n_i),
				.soft_rst_i(soft_rst_i),
				.wr_i(wr_ctrl),
				.wbit_i(wd[i]),
				.rd_i(1'b0),
				.hw_i(1'b0),
				.q_o(ctrl_o[i]),
				.rbit_o(ctrl_rb[i])
			);
		end
	endgenerate
	csrb_bit_cell #(
		.ATTR(`CSRB_ATTR_SELFCLR)
	) u_action (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.soft_rst_i(soft_rst_i),
		.wr_i(wr_ctrl),
		.wbit_i(wd[`CSRB_CTRL_ACT_BIT]),
		.rd_i(1'b0),
		.hw_i(1'b1),
		.q_o(action_o),
		.rbit_o(ctrl_rb[2*CW])
	);

	// Status: write-one-clear, read-clear, live read-only fields
	generate
		for (i = 0; i < 3*EW; i = i + 1) begin : g_sts
			csrb_bit_cell #(
				.ATTR((i < EW) ? `CSRB_ATTR_W1C : (i < 2*EW) ? `CSRB_ATTR_RDCLR : `CSRB_ATTR_RO)
			) u_cell (
				.clock_i(clock_i),
				.rst_n_i(rst_n_i),
				.soft_rst_i(soft_rst_i),
				.wr_i(wr_sts),
				.wbit_i(wd[i]),
				.rd_i(rd_sts),
				.hw_i((i < EW) ? evt_w1c_i[i % EW] : (i < 2*EW) ? evt_rc_i[i % EW] : live_i[i % EW]),
				.q_o(),
				.rbit_o(sts_rb[i])
			);
		end
	endgenerate

	// Command: write-only
	generate
		for (i = 0; i < CW; i = i + 1) begin : g_cmd
			csrb_bit_cell #(
				.ATTR(`CSRB_ATTR_WO)
			) u_cell (
				.clock_i(clock_i),
				.rst_n_i(rst_n_i),
				.soft_rst_i(soft_rst_i),
				.wr_i(wr_cmd),
				.wbit_i(wd[i]),
				.rd_i(1'b0),
				.hw_i(1'b0),
				.q_o(cmd_o[i]),
				.rbit_o(cmd_rb[i])
			);
		end
	endgenerate

	// PHY relay command: address, direction, busy
	generate
		for (i = 0; i <= `CSRB_PCMD_WR_BIT; i = i + 1) begin : g_pcmd
			csrb_bit_cell #(
				.ATTR(`CSRB_ATTR_RW)
			) u_cell (
				.clock_i(clock_i),
				.rst_n_i(rst_n_i),
				.soft_rst_i(soft_rst_i),
				.wr_i(wr_pcmd),
				.wbit_i(wd[i]),
				.rd_i(1'b0),
				.hw_i(1'b0),
				.q_o(pcmd_q[i]),
				.rbit_o()
			);
		end
	endgenerate
	csrb_bit_cell #(
		.ATTR(`CSRB_ATTR_SELFCLR)
	) u_busy (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.soft_rst_i(soft_rst_i),
		.wr_i(wr_pcmd),
		.wbit_i(wd[`CSRB_PCMD_BUSY_BIT]),
		.rd_i(1'b0),
		.hw_i(phy_done),
		.q_o(busy),
		.rbit_o()
	);

	assign relay_addr = pcmd_q[4:0];
	assign relay_go = busy & ~phy_done;
	assign relay_wr = relay_go & pcmd_q[`CSRB_PCMD_WR_BIT];
	assign relay_rd = relay_go & ~pcmd_q[`CSRB_PCMD_WR_BIT];
	assign phy_ctrl_wr = relay_wr & (relay_addr == `CSRB_PHY_REG_CTRL);
	assign phy_sts_rd = relay_rd & (relay_addr == `CSRB_PHY_REG_STS);
	assign pdata_load = relay_rd;

	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			phy_done <= 1'b0;
		end else begin
			phy_done <= relay_go;
		end
	end

	// PHY data: host writes it, relay reads land in it
	generate
		for (i = 0; i < PDW; i = i + 1) begin : g_pdata
			csrb_bit_cell #(
				.ATTR(`CSRB_ATTR_RW)
			) u_cell (
				.clock_i(clock_i),
				.rst_n_i(rst_n_i),
				.soft_rst_i(soft_rst_i),
				.wr_i(wr_pdata | pdata_load),
				.wbit_i(pdata_load ? phy_rval[i] : wd[i]),
				.rd_i(1'b0),
				.hw_i(1'b0),
				.q_o(pdata_q[i]),
				.rbit_o()
			);
		end
	endgenerate

	// PHY-resident control and latching status
	generate
		for (i = 0; i < PDW; i = i + 1) begin : g_pctl
			csrb_bit_cell #(
				.ATTR(`CSRB_ATTR_RW)
			) u_cell (
				.clock_i(clock_i),
				.rst_n_i(rst_n_i),
				.soft_rst_i(soft_rst_i),
				.wr_i(phy_ctrl_wr),
				.wbit_i(pdata_q[i]),
				.rd_i(1'b0),
				.hw_i(1'b0),
				.q_o(phy_ctrl_o[i]),
				.rbit_o()
			);
		end
		for (i = 0; i < 2*PW; i = i + 1) begin : g_psts
			csrb_bit_cell #(
				.ATTR((i < PW) ? `CSRB_ATTR_LATLO : `CSRB_ATTR_LATHI)
			) u_cell (
				.clock_i(clock_i),
				.rst_n_i(rst_n_i),
				.soft_rst_i(soft_rst_i),
				.wr_i(1'b0),
				.wbit_i(1'b0),
				.rd_i(phy_sts_rd),
				.hw_i((i < PW) ? phy_ll_cause_i[i % PW] : phy_lh_cause_i[i % PW]),
				.q_o(psts_q[i]),
				.rbit_o()
			);
		end
	endgenerate

	always @* begin
		phy_rval = {PDW{1'b0}};
		if (relay_addr == `CSRB_PHY_REG_CTRL) begin
			phy_rval = phy_ctrl_o;
		end else if (relay_addr == `CSRB_PHY_REG_STS) begin
			phy_rval[2*PW-1:0] = psts_q;
		end
	end

	// Read mux; reserved bits and unowned offsets read zero
	always @* begin
		rmux = `CSRB_ZERO32;
		if (sys_sel && (off == `CSRB_OFF_CTRL)) begin
			rmux[2*CW:0] = ctrl_rb;
		end else if (sys_sel && (off == `CSRB_OFF_STS)) begin
			rmux[3*EW-1:0] = sts_rb;
		end else if (sys_sel && (off == `CSRB_OFF_CMD)) begin
			rmux[CW-1:0] = cmd_rb;
		end else if (mac_sel && (off == `CSRB_OFF_PHY_CMD)) begin
			rmux[`CSRB_PCMD_WR_BIT:0] = pcmd_q;
			rmux[`CSRB_PCMD_BUSY_BIT] = busy;
		end else if (mac_sel && (off == `CSRB_OFF_PHY_DATA)) begin
			rmux[PDW-1:0] = pdata_q;
		end
	end

	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			pend <= 1'b0;
			pend_off <= {(`CSRB_AW-1){1'b0}};
			pend_sys <= 1'b0;
			pend_mac <= 1'b0;
			acc_rdata_o <= `CSRB_ZERO32;
			cmd_stb_o <= 1'b0;
		end else begin
			cmd_stb_o <= wr_cmd;
			if (take && !acc_write_i) begin
				pend <= 1'b1;
				pend_off <= off;
				pend_sys <= sys_sel;
				pend_mac <= mac_sel;
				acc_rdata_o <= swap ? {rmux[7:0], rmux[15:8], rmux[23:16], rmux[31:24]} : rmux;
			end else if (pend && (acc_commit_i || acc_abort_i)) begin
				pend <= 1'b0;
			end
		end
	end
endmodule // csrb_csr_space
`default_nettype wire

// [test/csrb_csr_space_properties.sv]
`timescale 1ns/1ns
`default_nettype none
module csrb_csr_space_chk #(
	parameter CW = 8,
	parameter PDW = 16
) (
	// Clock and resets
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic soft_rst_i,
	// Host access
	input wire logic acc_valid_i,
	input wire logic acc_write_i,
	input wire logic [9:0] acc_addr_i,
	input wire logic acc_commit_i,
	input wire logic acc_abort_i,
	input wire logic acc_ready_o,
	input wire logic acc_rvalid_o,
	input wire logic [31:0] acc_rdata_o,
	// Window and groups
	input wire logic third_bar_i,
	input wire logic big_endian_i,
	input wire logic grp_sys_o,
	input wire logic grp_dma_o,
	input wire logic grp_mac_o,
	// Device side
	input wire logic [2*CW-1:0] ctrl_o,
	input wire logic action_o,
	input wire logic [CW-1:0] cmd_o,
	input wire logic cmd_stb_o,
	input wire logic [PDW-1:0] phy_ctrl_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	wire logic req;
	assign req = acc_valid_i && acc_ready_o;
	AST_READ_ANSWER: assert property (req && !acc_write_i |=> acc_rvalid_o && !acc_ready_o)
		else $error("read not answered");
	AST_READ_HOLD: assert property (acc_rvalid_o && !acc_commit_i && !acc_abort_i
		|=> acc_rvalid_o && $stable(acc_rdata_o)) else $error("read data dropped");
	AST_SC_PULSE: assert property (action_o |=> !action_o) else $error("action stuck");
	AST_SC_CAUSE: assert property ($rose(action_o) |-> $past(req && acc_write_i))
		else $error("action without write");
	AST_IMMUNE_KEEP: assert property (soft_rst_i && !req |=> $stable(ctrl_o[2*CW-1:CW]))
		else $error("immune bits changed");
	AST_SOFT_CLEAR: assert property (soft_rst_i && !req |=> ctrl_o[CW-1:0] == 0 && cmd_o == 0 && phy_ctrl_o == 0)
		else $error("soft reset missed");
	AST_WO_STROBE: assert property (cmd_stb_o |-> $past(req && acc_write_i) || $past(req && acc_write_i, 2))
		else $error("strobe without write");
	AST_WRONG_HALF: assert property (third_bar_i && acc_addr_i[9] != big_endian_i |-> !(grp_sys_o || grp_dma_o || grp_mac_o))
		else $error("wrong half decoded");
	C_COMMIT: cover property (acc_rvalid_o && acc_commit_i);
	C_ABORT: cover property (acc_rvalid_o && acc_abort_i);
	C_ACTION: cover property (action_o);
endmodule // csrb_csr_space_chk
bind csrb_csr_space csrb_csr_space_chk #(.CW(CW), .PDW(PDW)) u_chk (.clock_i, .rst_n_i, .soft_rst_i, .acc_valid_i,
	.acc_write_i, .acc_addr_i, .acc_commit_i, .acc_abort_i, .acc_ready_o, .acc_rvalid_o, .acc_rdata_o, .third_bar_i,
	.big_endian_i, .grp_sys_o, .grp_dma_o, .grp_mac_o, .ctrl_o, .action_o, .cmd_o, .cmd_stb_o, .phy_ctrl_o);
`default_nettype wire

// [test/csrb_host.sv]
`timescale 1ns/1ns
`default_nettype none
module csrb_host (
	// Clock and answer
	input wire logic clock_i,
	input wire logic rvalid_i,
	input wire logic [31:0] rdata_i,
	// Request
	output logic valid_o,
	output logic write_o,
	output logic [9:0] addr_o,
	output logic [31:0] wdata_o,
	output logic commit_o,
	output logic abort_o
);
	initial {valid_o, write_o, addr_o, wdata_o, commit_o, abort_o} = '0;
	// One access; a read ends with commit or abort
	task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d, input logic ab,
		output logic [31:0] q);
		@(negedge clock_i);
		{valid_o, write_o, addr_o, wdata_o} = {1'b1, w, a, d};
		@(negedge clock_i);
		{valid_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
		q = rvalid_i ? rdata_i : 'x;
		if (!w) begin
			commit_o = !ab;
			abort_o = ab;
			@(negedge clock_i);
			{commit_o, abort_o} = '0;
		end
	endtask
endmodule // csrb_host
`default_nettype wire

// [test/tb_csr_bit_access_semantics.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_csr_bit_access_semantics;
	logic clock_i = 0;
	logic rst_n_i = 0;
	logic soft_rst_i = 0;
	logic third_bar_i = 0;
	logic big_endian_i = 0;
	logic [7:0] evt_w1c_i = 0;
	logic [7:0] evt_rc_i = 0;
	logic [7:0] live_i = 0;
	logic [3:0] phy_ll_cause_i = 0;
	logic [3:0] phy_lh_cause_i = 0;
	wire logic acc_valid_i, acc_write_i, acc_commit_i, acc_abort_i, acc_rvalid_o;
	wire logic [9:0] acc_addr_i;
	wire logic [31:0] acc_wdata_i, acc_rdata_o;
	wire logic [15:0] ctrl_o, phy_ctrl_o;
	wire logic [7:0] cmd_o;
	int n_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	csrb_host host_u (.clock_i, .rvalid_i(acc_rvalid_o), .rdata_i(acc_rdata_o), .valid_o(acc_valid_i),
		.write_o(acc_write_i), .addr_o(acc_addr_i), .wdata_o(acc_wdata_i), .commit_o(acc_commit_i),
		.abort_o(acc_abort_i));
	csrb_csr_space dut_u (.clock_i, .rst_n_i, .soft_rst_i, .acc_valid_i, .acc_write_i, .acc_cfg_i(1'b0),
		.acc_addr_i, .acc_wdata_i, .acc_commit_i, .acc_abort_i, .acc_ready_o(), .acc_rvalid_o, .acc_rdata_o,
		.third_bar_i, .big_endian_i, .grp_sys_o(), .grp_dma_o(), .grp_mac_o(), .grp_cfg_o(), .grp_off_o(), .ctrl_o,
		.action_o(), .cmd_o, .cmd_stb_o(), .evt_w1c_i, .evt_rc_i, .live_i, .phy_ll_cause_i, .phy_lh_cause_i,
		.phy_ctrl_o);
	initial forever #20 clock_i = ~clock_i;
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic [9:0] a, input logic [31:0] d);
		logic [31:0] q;
		host_u.xfer(1'b1, a, d, 1'b0, q);
	endtask
	task rd(input logic [9:0] a, input logic ab, output logic [31:0] q);
		host_u.xfer(1'b0, a, '0, ab, q);
	endtask
	task relay(input logic [31:0] c, output logic [31:0] q);
		wr(10'h1a4, c);
		repeat (3) @(negedge clock_i);
		rd(10'h1a8, 1'b0, q);
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 2000) begin
			n_errors++;
			give_verdict;
		end
	end
	initial begin
		logic [31:0] q, r, ev, m;
		r = $urandom(71);
		repeat (12) @(negedge clock_i);
		rst_n_i = 1;
		rd(10'h0e4, 1'b0, q);
		chk(q, '0);
		r = $urandom & 32'h0000_ffff;
		wr(10'h0e4, r | 32'h0001_0000);
		chk({16'h0000, ctrl_o}, r);
		rd(10'h0e4, 1'b0, q);
		chk(q, r);
		soft_rst_i = 1;
		@(negedge clock_i);
		soft_rst_i = 0;
		chk({16'h0000, ctrl_o}, r & 32'h0000_ff00);
		$display("control test done");
		ev = $urandom;
		live_i = ev[23:16];
		evt_w1c_i = ev[7:0];
		evt_rc_i = ev[15:8];
		@(negedge clock_i);
		{evt_w1c_i, evt_rc_i} = '0;
		m = ev & 32'h00ff_ffff;
		rd(10'h0e8, 1'b1, q);
		chk(q, m);
		rd(10'h0e8, 1'b0, q);
		chk(q, m);
		wr(10'h0e8, 32'h00ff_ff0f);
		rd(10'h0e8, 1'b0, q);
		chk(q, m & 32'h00ff_00f0);
		wr(10'h0ec, r & 32'h0000_00ff);
		chk({24'h00_0000, cmd_o}, r & 32'h0000_00ff);
		rd(10'h0ec, 1'b0, q);
		chk(q, '0);
		$display("status test done");
		third_bar_i = 1;
		big_endian_i = 1;
		wr(10'h2e4, 32'h3412_0000);
		rd(10'h0e4, 1'b0, q);
		chk(q, '0);
		big_endian_i = 0;
		rd(10'h0e4, 1'b0, q);
		chk(q, 32'h0000_1234);
		third_bar_i = 0;
		$display("window test done");
		wr(10'h1a8, r);
		relay(32'h8000_0020, q);
		chk({16'h0000, phy_ctrl_o}, r);
		relay(32'h8000_0001, q);
		phy_ll_cause_i = 4'h1;
		phy_lh_cause_i = 4'h2;
		@(negedge clock_i);
		{phy_ll_cause_i, phy_lh_cause_i} = '0;
		relay(32'h8000_0001, q);
		chk(q & 32'h0000_00ff, 32'h0000_002e);
		relay(32'h8000_0001, q);
		chk(q & 32'h0000_00ff, 32'h0000_000f);
		$display("relay test done");
		give_verdict;
	end
endmodule // tb_csr_bit_access_semantics
`default_nettype wire
